// ==== common/rio_pkg.sv ====
package rio_pkg;

    // ---------------------------------------------------------------
    // Frame geometry
    // ---------------------------------------------------------------
    localparam int FRAME_BYTES = 32;
    localparam int NUM_NODES = 8;
    localparam logic [7:0] CODE_V1 = 8'h50;
    localparam logic [7:0] CODE_V2 = 8'h20;
    localparam int V1_CODE_POS = 1;
    localparam int V1_IO_BASE = 7;
    localparam int V1_REG_BASE = 23;
    localparam int V2_CODE_POS = 0;
    localparam int V2_WDT_POS = 1;
    localparam int V2_CTRL_POS = 2;
    localparam int V2_IO_BASE = 6;
    localparam int V2_REG_BASE = 22;
    // Register area: address (2), code+trigger (2), data (4)
    localparam int REG_ADDR_OFS = 0;
    localparam int REG_CODE_OFS = 2;
    localparam int REG_DATA_OFS = 4;
    localparam int EXEC_TRIGGER_BIT = 6;
    localparam int STAT_BIT = 7;

    // ---------------------------------------------------------------
    // Switch defaults and link timing
    // ---------------------------------------------------------------
    localparam logic LINK_TARGET_CONVERTER = 1'b0;
    localparam logic [3:0] ADDR_ROTARY_DEFAULT = 4'h0;
    localparam logic [3:0] RATE_SWITCH_CONVERTER = 4'h7;
    localparam int SYS_CLK_HZ = 100_000_000;
    localparam int LINK_BPS = 625_000;
    localparam int BIT_CYCLES = SYS_CLK_HZ / LINK_BPS;
    // Executing a command takes this many cycles before completion shows
    localparam int EXEC_CYCLES = 4;

    typedef logic [7:0] rio_byte_t;

    function automatic int rio_io_pos(input logic variant2, input int node);
        return (variant2 ? V2_IO_BASE : V1_IO_BASE) + 2 * node;
    endfunction

    function automatic int rio_reg_pos(input logic variant2);
        return variant2 ? V2_REG_BASE : V1_REG_BASE;
    endfunction

endpackage

// ==== common/rio_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Byte stream carrying frames; cmd_first and rsp_first mark byte 0 of a frame.
interface rio_link_if;
    logic cmd_valid;
    logic cmd_first;
    logic [7:0] cmd_byte;
    logic rsp_valid;
    logic rsp_first;
    logic [7:0] rsp_byte;

    modport conv (output cmd_valid, output cmd_first, output cmd_byte,
                  input rsp_valid, input rsp_first, input rsp_byte);
    modport drv (input cmd_valid, input cmd_first, input cmd_byte,
                 output rsp_valid, output rsp_first, output rsp_byte);
endinterface
`default_nettype wire

// ==== core/rio_conv_end.sv ====
`timescale 1ns/1ps
`default_nettype none
// Converter end: sends one 32-byte command frame per request, one byte per
// link-bit-time enable, and captures the response frame into user ports.
module rio_conv_end (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    rio_link_if.conv link,
    input wire logic i_start,
    input wire logic i_variant2,
    input wire logic [7:0] i_watchdog_count,
    input wire logic [15:0] i_cmd_ctrl,
    input wire logic [127:0] i_io_words,
    input wire logic [15:0] i_reg_addr,
    input wire logic [6:0] i_cmd_code,
    input wire logic i_exec_trigger,
    input wire logic [31:0] i_reg_data,
    output logic o_busy,
    output logic o_rsp_done,
    output logic [127:0] o_io_words,
    output logic [7:0] o_watchdog_echo,
    output logic [15:0] o_reg_addr,
    output logic [6:0] o_cmd_code,
    output logic o_done_trigger,
    output logic o_status_err,
    output logic [31:0] o_reg_data
);
    logic [7:0] frame_r [rio_pkg::FRAME_BYTES];
    logic [7:0] rx_r [rio_pkg::FRAME_BYTES];
    logic [4:0] tx_idx_r;
    logic [4:0] rx_idx_r;
    logic [7:0] div_r;
    logic tick;
    logic var2_r;
    logic cmd_valid_r;
    logic cmd_first_r;
    logic [7:0] cmd_byte_r;

    assign tick = (div_r == 8'(rio_pkg::BIT_CYCLES - 1));
    assign link.cmd_valid = cmd_valid_r;
    assign link.cmd_first = cmd_first_r;
    assign link.cmd_byte = cmd_byte_r;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_r <= 8'h00;
        end else if (tick) begin
            div_r <= 8'h00;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end

    // ---------------------------------------------------------------
    // Frame build and send
    // ---------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_busy <= 1'b0;
            tx_idx_r <= 5'h00;
            var2_r <= 1'b0;
            cmd_valid_r <= 1'b0;
            cmd_first_r <= 1'b0;
            cmd_byte_r <= 8'h00;
            for (int i = 0; i < rio_pkg::FRAME_BYTES; i++) frame_r[i] <= 8'h00;
        end else begin
            cmd_valid_r <= 1'b0;
            cmd_first_r <= 1'b0;
            if (!o_busy && i_start) begin
                o_busy <= 1'b1;
                tx_idx_r <= 5'h00;
                var2_r <= i_variant2;
                for (int i = 0; i < rio_pkg::FRAME_BYTES; i++) frame_r[i] <= 8'h00;
                if (i_variant2) begin
                    frame_r[rio_pkg::V2_CODE_POS] <= rio_pkg::CODE_V2;
                    frame_r[rio_pkg::V2_WDT_POS] <= i_watchdog_count;
                    frame_r[rio_pkg::V2_CTRL_POS] <= i_cmd_ctrl[7:0];
                    frame_r[rio_pkg::V2_CTRL_POS + 1] <= i_cmd_ctrl[15:8];
                end else begin
                    frame_r[rio_pkg::V1_CODE_POS] <= rio_pkg::CODE_V1;
                end
                for (int n = 0; n < rio_pkg::NUM_NODES; n++) begin
                    frame_r[rio_pkg::rio_io_pos(i_variant2, n)] <= i_io_words[16*n +: 8];
                    frame_r[rio_pkg::rio_io_pos(i_variant2, n) + 1] <=
                        i_io_words[16*n+8 +: 8];
                end
                for (int b = 0; b < 2; b++) begin
                    frame_r[rio_pkg::rio_reg_pos(i_variant2) + rio_pkg::REG_ADDR_OFS + b]
                        <= i_reg_addr[8*b +: 8];
                end
                // Converter copies i_exec_trigger into the trigger bit as given for every command
                frame_r[rio_pkg::rio_reg_pos(i_variant2) + rio_pkg::REG_CODE_OFS] <=
                    {1'b0, i_exec_trigger, i_cmd_code[5:0]};
                frame_r[rio_pkg::rio_reg_pos(i_variant2) + rio_pkg::REG_CODE_OFS + 1] <=
                    {7'h00, i_cmd_code[6]};
                for (int b = 0; b < 4; b++) begin
                    frame_r[rio_pkg::rio_reg_pos(i_variant2) + rio_pkg::REG_DATA_OFS + b]
                        <= i_reg_data[8*b +: 8];
                end
            end else if (o_busy && tick) begin
                cmd_valid_r <= 1'b1;
                cmd_first_r <= (tx_idx_r == 5'h00);
                cmd_byte_r <= frame_r[tx_idx_r];
                tx_idx_r <= tx_idx_r + 5'h01;
                if (tx_idx_r == 5'(rio_pkg::FRAME_BYTES - 1)) begin
                    o_busy <= 1'b0;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Response capture
    // ---------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_idx_r <= 5'h00;
            o_rsp_done <= 1'b0;
            for (int i = 0; i < rio_pkg::FRAME_BYTES; i++) rx_r[i] <= 8'h00;
        end else begin
            o_rsp_done <= 1'b0;
            if (link.rsp_valid) begin
                rx_r[link.rsp_first ? 5'h00 : rx_idx_r] <= link.rsp_byte;
                rx_idx_r <= link.rsp_first ? 5'h01 : rx_idx_r + 5'h01;
                if (!link.rsp_first && rx_idx_r == 5'(rio_pkg::FRAME_BYTES - 1)) begin
                    o_rsp_done <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_io_words <= '0;
            o_watchdog_echo <= 8'h00;
            o_reg_addr <= 16'h0000;
            o_cmd_code <= 7'h00;
            o_done_trigger <= 1'b0;
            o_status_err <= 1'b0;
            o_reg_data <= 32'h0000_0000;
        end else if (o_rsp_done) begin
            for (int n = 0; n < rio_pkg::NUM_NODES; n++) begin
                o_io_words[16*n +: 16] <= {rx_r[rio_pkg::rio_io_pos(var2_r, n) + 1],
                                           rx_r[rio_pkg::rio_io_pos(var2_r, n)]};
            end
            o_watchdog_echo <= rx_r[rio_pkg::V2_WDT_POS];
            o_reg_addr <= {rx_r[rio_pkg::rio_reg_pos(var2_r) + 1],
                           rx_r[rio_pkg::rio_reg_pos(var2_r)]};
            o_cmd_code <= {rx_r[rio_pkg::rio_reg_pos(var2_r) + 3][0],
                           rx_r[rio_pkg::rio_reg_pos(var2_r) + 2][5:0]};
            o_done_trigger <= rx_r[rio_pkg::rio_reg_pos(var2_r) + 2][rio_pkg::EXEC_TRIGGER_BIT];
            o_status_err <= rx_r[rio_pkg::rio_reg_pos(var2_r) + 2][rio_pkg::STAT_BIT];
            for (int b = 0; b < 4; b++) begin
                o_reg_data[8*b +: 8] <= rx_r[rio_pkg::rio_reg_pos(var2_r) + 4 + b];
            end
        end
    end
endmodule
`default_nettype wire

// ==== core/rio_drv_end.sv ====
`timescale 1ns/1ps
`default_nettype none
module rio_drv_end (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    rio_link_if.drv link,
    input wire logic i_link_target_switch,
    input wire logic i_address_extend_switch,
    input wire logic [3:0] i_address_rotary_switch,
    input wire logic [3:0] i_rate_switch,
    input wire logic [15:0] i_io_status,
    input wire logic [31:0] i_reg_rdata,
    input wire logic i_reg_err,
    output logic o_cfg_valid,
    output logic [4:0] o_node_addr,
    output logic o_link_ok,
    output logic [15:0] o_io_ctrl,
    output logic o_exec_pulse,
    output logic [15:0] o_reg_addr,
    output logic [6:0] o_cmd_code,
    output logic [31:0] o_reg_wdata
);
    typedef enum logic [1:0] {IDLE, EXEC, REPLY} rio_exec_e;

    logic [7:0] rx_r [rio_pkg::FRAME_BYTES];
    logic [7:0] tx_r [rio_pkg::FRAME_BYTES];
    logic [4:0] rx_idx_r;
    logic [4:0] tx_idx_r;
    logic frame_done_r;
    logic var2_r;
    logic tx_busy_r;
    logic exec_trigger_prev_r;
    logic done_done_trigger;
    logic err_r;
    logic [31:0] rdata_r;
    logic [2:0] exec_cnt_r;
    rio_exec_e state_r;
    logic rsp_valid_r;
    logic rsp_first_r;
    logic [7:0] rsp_byte_r;
    logic [7:0] code_lo;
    logic exec_trigger_now;
    logic my_frame;
    int io_pos;
    int reg_pos;

    assign link.rsp_valid = rsp_valid_r;
    assign link.rsp_first = rsp_first_r;
    assign link.rsp_byte = rsp_byte_r;
    assign reg_pos = rio_pkg::rio_reg_pos(var2_r);
    assign io_pos = rio_pkg::rio_io_pos(var2_r, int'(o_node_addr[2:0]));
    assign code_lo = rx_r[reg_pos + rio_pkg::REG_CODE_OFS];
    assign exec_trigger_now = code_lo[rio_pkg::EXEC_TRIGGER_BIT];
    // Only the eight-node frame map is carried, so extended addresses never match
    assign my_frame = o_link_ok && !o_node_addr[4] && !o_node_addr[3];

    // ---------------------------------------------------------------
    // Setup switches
    // ---------------------------------------------------------------
    // Later switch moves are ignored until the next reset
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cfg_valid <= 1'b0;
            o_node_addr <= 5'h00;
            o_link_ok <= 1'b0;
        end else if (!o_cfg_valid) begin
            o_cfg_valid <= 1'b1;
            // Extend switch adds sixteen to the rotary value
            o_node_addr <= {i_address_extend_switch, i_address_rotary_switch};
            // Converter link needs target off and rate position 7
            o_link_ok <= (i_link_target_switch == rio_pkg::LINK_TARGET_CONVERTER) &&
                         (i_rate_switch == rio_pkg::RATE_SWITCH_CONVERTER);
        end
    end

    // ---------------------------------------------------------------
    // Frame receive and variant detection
    // ---------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_idx_r <= 5'h00;
            frame_done_r <= 1'b0;
            var2_r <= 1'b0;
            for (int i = 0; i < rio_pkg::FRAME_BYTES; i++) rx_r[i] <= 8'h00;
        end else begin
            frame_done_r <= 1'b0;
            if (link.cmd_valid) begin
                rx_r[link.cmd_first ? 5'h00 : rx_idx_r] <= link.cmd_byte;
                rx_idx_r <= link.cmd_first ? 5'h01 : rx_idx_r + 5'h01;
                if (!link.cmd_first && rx_idx_r == 5'(rio_pkg::FRAME_BYTES - 1)) begin
                    if (rx_r[rio_pkg::V2_CODE_POS] == rio_pkg::CODE_V2) begin
                        var2_r <= 1'b1;
                        frame_done_r <= 1'b1;
                    end else if (rx_r[rio_pkg::V1_CODE_POS] == rio_pkg::CODE_V1) begin
                        var2_r <= 1'b0;
                        frame_done_r <= 1'b1;
                    end
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Remote I/O and command execution
    // ---------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_io_ctrl <= 16'h0000;
            o_reg_addr <= 16'h0000;
            o_cmd_code <= 7'h00;
            o_reg_wdata <= 32'h0000_0000;
            o_exec_pulse <= 1'b0;
            exec_trigger_prev_r <= 1'b0;
            done_done_trigger <= 1'b0;
            err_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            exec_cnt_r <= 3'h0;
            state_r <= IDLE;
        end else begin
            o_exec_pulse <= 1'b0;
            if (frame_done_r && my_frame) begin
                o_io_ctrl <= {rx_r[io_pos + 1], rx_r[io_pos]};
                exec_trigger_prev_r <= exec_trigger_now;
                // Trigger low clears the done echo so the next 0-to-1 is visible
                if (!exec_trigger_now) begin
                    done_done_trigger <= 1'b0;
                end
            end
            case (state_r)
                IDLE: begin
                    if (frame_done_r && my_frame && exec_trigger_now && !exec_trigger_prev_r) begin
                        o_reg_addr <= {rx_r[reg_pos + 1], rx_r[reg_pos]};
                        o_cmd_code <= {rx_r[reg_pos + 3][0], code_lo[5:0]};
                        for (int b = 0; b < 4; b++) begin
                            o_reg_wdata[8*b +: 8] <=
                                rx_r[reg_pos + rio_pkg::REG_DATA_OFS + b];
                        end
                        o_exec_pulse <= 1'b1;
                        exec_cnt_r <= 3'h0;
                        state_r <= EXEC;
                    end
                end
                EXEC: begin
                    exec_cnt_r <= exec_cnt_r + 3'h1;
                    if (exec_cnt_r == 3'(rio_pkg::EXEC_CYCLES - 1)) begin
                        rdata_r <= i_reg_rdata;
                        err_r <= i_reg_err;
                        state_r <= REPLY;
                    end
                end
                default: begin
                    done_done_trigger <= 1'b1;
                    state_r <= IDLE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Response frame send, one byte per cycle after a frame ends
    // ---------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_busy_r <= 1'b0;
            tx_idx_r <= 5'h00;
            rsp_valid_r <= 1'b0;
            rsp_first_r <= 1'b0;
            rsp_byte_r <= 8'h00;
            for (int i = 0; i < rio_pkg::FRAME_BYTES; i++) tx_r[i] <= 8'h00;
        end else begin
            rsp_valid_r <= 1'b0;
            rsp_first_r <= 1'b0;
            if (frame_done_r && my_frame && !tx_busy_r) begin
                tx_busy_r <= 1'b1;
                tx_idx_r <= 5'h00;
                for (int i = 0; i < rio_pkg::FRAME_BYTES; i++) tx_r[i] <= 8'h00;
                tx_r[rio_pkg::V2_CODE_POS] <= var2_r ? rio_pkg::CODE_V2 : 8'h00;
                tx_r[rio_pkg::V1_CODE_POS] <= var2_r ? rx_r[rio_pkg::V2_WDT_POS]
                                                     : rio_pkg::CODE_V1;
                tx_r[io_pos] <= i_io_status[7:0];
                tx_r[io_pos + 1] <= i_io_status[15:8];
                tx_r[reg_pos] <= rx_r[reg_pos];
                tx_r[reg_pos + 1] <= rx_r[reg_pos + 1];
                tx_r[reg_pos + 2] <= {err_r, done_done_trigger, code_lo[5:0]};
                tx_r[reg_pos + 3] <= rx_r[reg_pos + 3];
                for (int b = 0; b < 4; b++) begin
                    tx_r[reg_pos + rio_pkg::REG_DATA_OFS + b] <= rdata_r[8*b +: 8];
                end
            end else if (tx_busy_r) begin
                rsp_valid_r <= 1'b1;
                rsp_first_r <= (tx_idx_r == 5'h00);
                rsp_byte_r <= tx_r[tx_idx_r];
                tx_idx_r <= tx_idx_r + 5'h01;
                if (tx_idx_r == 5'(rio_pkg::FRAME_BYTES - 1)) begin
                    tx_busy_r <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== test/rio_link_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module rio_link_sva (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic cmd_valid,
    input wire logic cmd_first,
    input wire logic [7:0] cmd_byte,
    input wire logic rsp_valid,
    input wire logic rsp_first,
    input wire logic [7:0] rsp_byte
);
    // ----------------------------------------
    // Frame position trackers
    // ----------------------------------------
    logic [5:0] ccnt_r;
    logic [5:0] rcnt_r;
    logic [8:0] gap_r;
    logic v2_r;
    logic [7:0] cmem_r [0:31];
    int rb;
    assign rb = v2_r ? rio_pkg::V2_REG_BASE : rio_pkg::V1_REG_BASE;
    // Command bytes are kept so the reply can be compared against them
    always_ff @(posedge i_sys_clk) begin
        if (cmd_valid) begin
            cmem_r[cmd_first ? 5'h00 : ccnt_r[4:0]] <= cmd_byte;
        end
    end
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ccnt_r <= 6'h00;
            rcnt_r <= 6'h00;
            gap_r <= 9'h000;
            v2_r <= 1'b0;
        end else begin
            gap_r <= cmd_valid ? 9'h000 : gap_r + 9'h001;
            if (cmd_valid) begin
                ccnt_r <= cmd_first ? 6'h01 : ccnt_r + 6'h01;
            end
            if (cmd_first) begin
                v2_r <= cmd_byte == rio_pkg::CODE_V2;
            end
            if (rsp_valid) begin
                rcnt_r <= rsp_first ? 6'h01 : rcnt_r + 6'h01;
            end
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    a_cmd_first_valid: assert property (cmd_first |-> cmd_valid)
        else $error("cmd_first without cmd_valid");
    a_cmd_bit_rate: assert property (cmd_valid && !cmd_first |-> gap_r == 9'h09F)
        else $error("command byte spacing wrong");
    a_cmd_frame_len: assert property (cmd_first |-> ccnt_r == 6'h00 || ccnt_r == 6'h20)
        else $error("command frame length wrong");
    a_cmd_v1_code: assert property (cmd_valid && !cmd_first && ccnt_r == 6'h01 && !v2_r
        |-> cmd_byte == rio_pkg::CODE_V1) else $error("variant one command code wrong");
    a_rsp_v2_code: assert property (rsp_first && v2_r |-> rsp_byte == rio_pkg::CODE_V2)
        else $error("variant two reply code wrong");
    a_rsp_v1_code: assert property (rsp_valid && !rsp_first && rcnt_r == 6'h01 && !v2_r
        |-> rsp_byte == rio_pkg::CODE_V1) else $error("variant one reply code wrong");
    a_wdt_echo_ok: assert property (rsp_valid && !rsp_first && rcnt_r == 6'h01 && v2_r
        |-> rsp_byte == cmem_r[1]) else $error("watchdog echo wrong");
    a_reply_follows: assert property (cmd_valid && ccnt_r == 6'h1F |-> ##[1:8] rsp_first)
        else $error("no reply after command frame");
    a_reg_addr_echo: assert property (rsp_valid && !rsp_first && (rcnt_r == rb ||
        rcnt_r == rb + 1) |-> rsp_byte == cmem_r[rcnt_r[4:0]]) else $error("address echo wrong");
    a_reg_code_echo: assert property (rsp_valid && !rsp_first && rcnt_r == rb + 2
        |-> rsp_byte[5:0] == cmem_r[rb + 2][5:0]) else $error("code echo wrong");
    a_rsp_burst_on: assert property (rsp_first |=> rsp_valid [*8])
        else $error("reply bytes not back to back");
    c_v2_frame: cover property (cmd_first && cmd_byte == rio_pkg::CODE_V2);
    c_done_seen: cover property (rsp_valid && rcnt_r == rb + 2 && rsp_byte[6]);
    c_err_seen: cover property (rsp_valid && rcnt_r == rb + 2 && rsp_byte[7]);
endmodule
`default_nettype wire

// ==== test/tb_remote_io_frame_map.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_remote_io_frame_map;
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic c_start = 1'b0;
    logic c_v2 = 1'b0;
    logic c_exec_trigger = 1'b0;
    logic [7:0] c_wdt = 8'h00;
    logic [15:0] c_ctrl = 16'h0000;
    logic [127:0] c_io = '0;
    logic [15:0] c_addr = 16'h0000;
    logic [6:0] c_code = 7'h00;
    logic [31:0] c_data = 32'h0;
    logic c_busy, c_done, c_dtrig, c_err, d_cfg, d_ok, d_exec;
    logic [127:0] c_io_o;
    logic [7:0] c_wecho;
    logic [15:0] c_addr_o, d_ioc, d_addr;
    logic [6:0] c_code_o, d_code;
    logic [31:0] c_data_o, d_wd;
    logic [4:0] d_node;
    logic d_lt = rio_pkg::LINK_TARGET_CONVERTER;
    logic d_ext = 1'b0;
    logic [3:0] d_rot = 4'h0;
    logic [3:0] d_rate = rio_pkg::RATE_SWITCH_CONVERTER;
    logic [15:0] d_st = 16'h0000;
    logic [31:0] d_rd = 32'h0;
    logic d_rerr = 1'b0;
    logic [7:0] cfr [0:31];
    logic [7:0] rfr [0:31];
    logic [5:0] tgs = 6'h36;
    logic pv_tg = 1'b0;
    logic dn_m = 1'b0;
    logic er_m = 1'b0;
    logic [31:0] dt_m = 32'h0;
    logic [15:0] ad_m = 16'h0000;
    logic [6:0] cd_m = 7'h00;
    logic [31:0] wd_m = 32'h0;
    int cp = 0, rp = 0, n_exec = 0, cyc = 0, nd = 0, err_total = 0, n_tests = 0;

    rio_link_if link ();
    rio_conv_end rio_conv_end_i (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .link(link), .i_start(c_start),
        .i_variant2(c_v2), .i_watchdog_count(c_wdt), .i_cmd_ctrl(c_ctrl), .i_io_words(c_io),
        .i_reg_addr(c_addr), .i_cmd_code(c_code), .i_exec_trigger(c_exec_trigger),
        .i_reg_data(c_data), .o_busy(c_busy), .o_rsp_done(c_done), .o_io_words(c_io_o),
        .o_watchdog_echo(c_wecho), .o_reg_addr(c_addr_o), .o_cmd_code(c_code_o),
        .o_done_trigger(c_dtrig), .o_status_err(c_err), .o_reg_data(c_data_o)
    );
    rio_drv_end rio_drv_end_i (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .link(link), .i_link_target_switch(d_lt),
        .i_address_extend_switch(d_ext), .i_address_rotary_switch(d_rot),
        .i_rate_switch(d_rate), .i_io_status(d_st), .i_reg_rdata(d_rd), .i_reg_err(d_rerr),
        .o_cfg_valid(d_cfg), .o_node_addr(d_node), .o_link_ok(d_ok), .o_io_ctrl(d_ioc),
        .o_exec_pulse(d_exec), .o_reg_addr(d_addr), .o_cmd_code(d_code), .o_reg_wdata(d_wd)
    );
    rio_link_sva rio_link_sva_i (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .cmd_valid(link.cmd_valid),
        .cmd_first(link.cmd_first), .cmd_byte(link.cmd_byte), .rsp_valid(link.rsp_valid),
        .rsp_first(link.rsp_first), .rsp_byte(link.rsp_byte)
    );

    always #5 i_sys_clk = ~i_sys_clk;

    // ----------------------------------------
    // Wire monitor, sampled mid-cycle so flop outputs have settled
    // ----------------------------------------
    always @(negedge i_sys_clk) begin
        cyc++;
        if (d_exec === 1'b1) n_exec++;
        if (link.cmd_valid === 1'b1) begin
            cp = link.cmd_first ? 0 : cp + 1;
            cfr[cp[4:0]] = link.cmd_byte;
        end
        if (link.rsp_valid === 1'b1) begin
            rp = link.rsp_first ? 0 : rp + 1;
            rfr[rp[4:0]] = link.rsp_byte;
        end
        if (cyc == 80000) begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic chk(input string nm, input logic [127:0] ex, input logic [127:0] got);
        n_tests++;
        if (got !== ex) begin
            err_total++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // One command frame and its reply; the model tracks trigger and done state
    task automatic frame(input logic v, input logic tg, input logic er);
        int k, b, io, ex0;
        logic rise;
        logic [127:0] ex;
        b = v ? rio_pkg::V2_REG_BASE : rio_pkg::V1_REG_BASE;
        io = (v ? rio_pkg::V2_IO_BASE : rio_pkg::V1_IO_BASE) + 2 * nd;
        rise = tg && !pv_tg;
        c_v2 = v;
        c_exec_trigger = tg;
        c_wdt = 8'($urandom);
        c_io = {$urandom, $urandom, $urandom, $urandom};
        c_addr = 16'($urandom);
        c_code = 7'($urandom);
        c_data = $urandom;
        d_st = 16'($urandom);
        if (rise) begin
            d_rd = $urandom;
            d_rerr = er;
            ad_m = c_addr;
            cd_m = c_code;
            wd_m = c_data;
        end
        ex0 = n_exec;
        c_start = 1'b1;
        @(negedge i_sys_clk);
        c_start = 1'b0;
        chk("busy_on", 128'(1), 128'(c_busy));
        for (k = 0; k < 6000 && c_done !== 1'b1; k++) @(negedge i_sys_clk);
        chk("rsp_done", 128'(1), 128'(c_done));
        chk("busy_off", 128'(0), 128'(c_busy));
        @(negedge i_sys_clk);
        ex = '0;
        ex[16*nd+:16] = d_st;
        chk("node", 128'(nd), 128'(d_node));
        chk("io_ctrl", 128'(c_io[16*nd+:16]), 128'(d_ioc));
        chk("drv_addr", 128'(ad_m), 128'(d_addr));
        chk("drv_code", 128'(cd_m), 128'(d_code));
        chk("drv_wdata", 128'(wd_m), 128'(d_wd));
        chk("exec_count", 128'(rise), 128'(n_exec - ex0));
        chk("rsp_io", ex, c_io_o);
        chk("rsp_addr", 128'(c_addr), 128'(c_addr_o));
        chk("rsp_code", 128'(c_code), 128'(c_code_o));
        if (v) chk("wdt_echo", 128'(c_wdt), 128'(c_wecho));
        chk("done_exec_trigger", 128'(dn_m), 128'(c_dtrig));
        if (dn_m) chk("status", 128'(er_m), 128'(c_err));
        if (dn_m) chk("rsp_data", 128'(dt_m), 128'(c_data_o));
        chk("code_pos", 128'(v ? 8'h20 : 8'h50), 128'(cfr[v ? 0 : 1]));
        chk("data_lsb", 128'(c_data[7:0]), 128'(cfr[b + 4]));
        chk("data_msb", 128'(c_data[31:24]), 128'(cfr[b + 7]));
        chk("rsp_io_lo", 128'(d_st[7:0]), 128'(rfr[io]));
        chk("rsp_io_hi", 128'(d_st[15:8]), 128'(rfr[io + 1]));
        if (!tg) begin
            dn_m = 1'b0;
        end else if (rise) begin
            dn_m = 1'b1;
            er_m = er;
            dt_m = d_rd;
        end
        pv_tg = tg;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        int s;
        s = $urandom(32'hC9EC);
        d_rot = 4'($urandom_range(7, 0));
        nd = int'(d_rot);
        repeat (3) @(negedge i_sys_clk);
        i_rst_n = 1'b1;
        repeat (3) @(negedge i_sys_clk);
        chk("cfg_valid", 128'(1), 128'(d_cfg));
        chk("link_ok", 128'(1), 128'(d_ok));
        chk("node", 128'(nd), 128'(d_node));
        // Moving the switch while running must not move the node
        d_rot = 4'(d_rot[2:0] + 3'h1);
        for (int i = 0; i < 12; i++) begin
            frame(i >= 6, tgs[i % 6], i % 6 == 4);
            $display("test %0d done", i);
        end
        // Extend switch is only seen at the next reset
        d_ext = 1'b1;
        i_rst_n = 1'b0;
        @(negedge i_sys_clk);
        i_rst_n = 1'b1;
        repeat (2) @(negedge i_sys_clk);
        chk("node_ext", 128'(16 + int'(d_rot)), 128'(d_node));
        $display("test ext done");
        report_and_stop();
    end
endmodule
`default_nettype wire
